// >>> logic/esb_defines.svh
`ifndef ESB_DEFINES_SVH
`define ESB_DEFINES_SVH
`define ESB_ISB_POS 24
`define ESB_HI_MSB 26
`define ESB_HI_LSB 25
`define ESB_LO_MSB 15
`define ESB_LO_LSB 10
`define ESB_REG_MSB 15
`define ESB_REG_LSB 12
`define ESB_CONT_ZERO_MSB 11
`define ESB_CONT_ZERO_LSB 10
`define ESB_MASK 32'h0700fc00
`define ESB_ISB_RST 1'b1
`define ESB_STATE_RST 8'h00
`endif

// >>> logic/esb_pkg.sv
package esb_pkg;
  typedef enum logic [2:0] {
    ESB_VIEW_FULL,
    ESB_VIEW_EXEC,
    ESB_VIEW_EXEC_INT,
    ESB_VIEW_APP_EXEC,
    ESB_VIEW_APP_INT,
    ESB_VIEW_APP,
    ESB_VIEW_INT
  } esb_view_e;
  typedef enum logic [1:0] {
    ESB_ST_RUN,
    ESB_ST_FAULT,
    ESB_ST_LOCKUP
  } esb_run_e;
endpackage

// >>> logic/esb_cond_check.sv
`timescale 1ns/1ps
`default_nettype none
// condition check for one block instruction against the block state
module esb_cond_check
  import esb_pkg::*;
(
  // block state
  input wire logic [7:0] state_in,
  // condition of the issuing instruction
  input wire logic [3:0] cond_in,
  // result
  output logic match_out
);
  // upper three bits are the base; bit 4 selects base or inverse
  always_comb
  begin
    match_out = (cond_in[3:1] == state_in[7:5]) &&
                (cond_in[0] == state_in[4]);
  end
endmodule
`default_nettype wire

// >>> logic/esb_exec_state.sv
`timescale 1ns/1ps
`default_nettype none
`include "esb_defines.svh"
module esb_exec_state
  import esb_pkg::*;
#(
  // field and register-number widths; only the status-word layout is served
  parameter int unsigned FIELD_W = 8,
  parameter int unsigned REG_NUM_W = 4
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // reset vector value, bit 0 is sampled
  input wire logic [31:0] rst_vector_in,
  // exception entry
  input wire logic exc_entry_in,
  input wire logic [31:0] exc_vector_in,
  // exception return
  input wire logic exc_return_in,
  input wire logic [31:0] stacked_status_word_in,
  // register branches and pop into pc
  input wire logic branch_via_register_in,
  input wire logic branch_link_via_register_in,
  input wire logic pop_into_program_counter_in,
  input wire logic [31:0] branch_target_in,
  // conditional-block prefix: 8-bit state from the 16-bit opcode
  input wire logic conditional_block_prefix_in,
  input wire logic [7:0] cond_block_state_in,
  // instruction retire
  input wire logic instr_issue_in,
  input wire logic instr_done_in,
  input wire logic [3:0] instr_cond_in,
  // multi-register transfer
  input wire logic multi_interrupt_in,
  input wire logic [3:0] multi_next_reg_in,
  input wire logic multi_resume_in,
  // status-word reads and writes
  input wire logic status_rd_in,
  input wire esb_pkg::esb_view_e status_view_in,
  input wire logic status_direct_in,
  input wire logic status_wr_in,
  input wire logic [31:0] status_wdata_in,
  // outputs
  output logic [31:0] status_rdata_out,
  output logic isb_out,
  output logic [3:0] resume_reg_out,
  output logic resume_valid_out,
  output logic cond_pass_out,
  output logic in_block_out,
  output logic fault_out,
  output logic lockup_out
);
  import esb_pkg::*;

  // the split field and register number are fixed by the status-word layout
  if (FIELD_W != 8)
  begin : g_bad_field_w
    $error("field width must be 8");
  end
  if (REG_NUM_W != 4)
  begin : g_bad_reg_num_w
    $error("register number width must be 4");
  end

  ////////////////////////////////////////////////////////////////////////
  logic isb_r, isb_nxt;
  logic [FIELD_W-1:0] state_r, state_nxt;
  logic cont_r, cont_nxt;
  esb_run_e run_r, run_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [REG_NUM_W-1:0] resume_reg_r, resume_reg_nxt;
  logic resume_valid_r, resume_valid_nxt;
  logic pass_r, pass_nxt;
  logic in_block_r, in_block_nxt;
  logic fault_r, fault_nxt;
  logic lockup_r, lockup_nxt;
  logic match;
  logic [31:0] field_word;
  logic [31:0] exec_word;
  logic show;

  esb_cond_check u_cond
  (
    .state_in(state_r),
    .cond_in(instr_cond_in),
    .match_out(match)
  );

  ////////////////////////////////////////////////////////////////////////
  // instruction-set state bit; status writes never touch it
  always_comb
  begin
    isb_nxt = isb_r;
    if (exc_entry_in)
      isb_nxt = exc_vector_in[0];
    else if (exc_return_in)
      isb_nxt = stacked_status_word_in[`ESB_ISB_POS];
    else if (branch_via_register_in || branch_link_via_register_in ||
             pop_into_program_counter_in)
      isb_nxt = branch_target_in[0];
  end

  // reset vector bit 0 is captured by the clocked reset branch
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      isb_r <= rst_vector_in[0] & `ESB_ISB_RST;
    else
      isb_r <= isb_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // split field: cont_r marks continuation content, else block content
  always_comb
  begin
    state_nxt = state_r;
    cont_nxt = cont_r;
    resume_reg_nxt = resume_reg_r;
    resume_valid_nxt = 1'b0;
    if (exc_entry_in)
    begin
      if (multi_interrupt_in)
      begin
        state_nxt = {2'h0, multi_next_reg_in, 2'h0};
        cont_nxt = 1'b1;
      end
    end
    else if (exc_return_in)
    begin
      state_nxt = {stacked_status_word_in[`ESB_HI_MSB:`ESB_HI_LSB],
                   stacked_status_word_in[`ESB_LO_MSB:`ESB_LO_LSB]};
      cont_nxt = (stacked_status_word_in[`ESB_HI_MSB:`ESB_HI_LSB] == 2'h0)
                 && (stacked_status_word_in[`ESB_CONT_ZERO_MSB:
                                            `ESB_CONT_ZERO_LSB] == 2'h0)
                 && (stacked_status_word_in[`ESB_REG_MSB:`ESB_REG_LSB]
                     != 4'h0);
    end
    else if (cont_r && multi_resume_in)
    begin
      resume_reg_nxt = state_r[5:2];
      resume_valid_nxt = 1'b1;
      state_nxt = `ESB_STATE_RST;
      cont_nxt = 1'b0;
    end
    else if (conditional_block_prefix_in)
    begin
      state_nxt = cond_block_state_in;
      cont_nxt = 1'b0;
    end
    else if (!cont_r && instr_done_in && state_r[3:0] != 4'h0)
    begin
      // shift mask; when only the stop bit remains the block is over
      if (state_r[2:0] == 3'h0)
        state_nxt = `ESB_STATE_RST;
      else
        state_nxt = {state_r[7:5], state_r[3:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= `ESB_STATE_RST;
      cont_r <= 1'b0;
      resume_reg_r <= 4'h0;
      resume_valid_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cont_r <= cont_nxt;
      resume_reg_r <= resume_reg_nxt;
      resume_valid_r <= resume_valid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // execution: clear bit faults; an exception entry with vector bit 0 clear while faulted locks up
  always_comb
  begin
    run_nxt = run_r;
    pass_nxt = 1'b0;
    case (run_r)
      ESB_ST_RUN:
      begin
        if (instr_issue_in && !isb_r)
          run_nxt = ESB_ST_FAULT;
        else if (instr_issue_in)
          pass_nxt = (cont_r || state_r[3:0] == 4'h0) ? 1'b1 : match;
      end
      ESB_ST_FAULT:
      begin
        if (exc_entry_in && !exc_vector_in[0])
          run_nxt = ESB_ST_LOCKUP;
        else if (exc_entry_in || exc_return_in)
          run_nxt = ESB_ST_RUN;
      end
      ESB_ST_LOCKUP:
        run_nxt = ESB_ST_LOCKUP;
      default:
        run_nxt = ESB_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      run_r <= ESB_ST_RUN;
      pass_r <= 1'b0;
    end
    else
    begin
      run_r <= run_nxt;
      pass_r <= pass_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags come from the next state so every output leaves a flip-flop
  // with the timing a decode of the current state would have
  always_comb
  begin
    in_block_nxt = !cont_nxt && (state_nxt[3:0] != 4'h0);
    fault_nxt = (run_nxt == ESB_ST_FAULT);
    lockup_nxt = (run_nxt == ESB_ST_LOCKUP);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      in_block_r <= 1'b0;
      fault_r <= 1'b0;
      lockup_r <= 1'b0;
    end
    else
    begin
      in_block_r <= in_block_nxt;
      fault_r <= fault_nxt;
      lockup_r <= lockup_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: reserved bits always zero, writes to these bits ignored
  // each status bit takes a field bit, the state bit, or a reserved zero
  for (genvar i = 0; i < 32; i++)
  begin : g_place
    if (i >= `ESB_LO_LSB && i <= `ESB_LO_MSB)
    begin : g_lo
      assign field_word[i] = state_r[i - `ESB_LO_LSB];
    end
    else if (i >= `ESB_HI_LSB && i <= `ESB_HI_MSB)
    begin : g_hi
      assign field_word[i] = state_r[i - `ESB_HI_LSB + 6];
    end
    else if (i == `ESB_ISB_POS)
    begin : g_isb
      assign field_word[i] = isb_r;
    end
    else
    begin : g_rsv
      assign field_word[i] = 1'b0;
    end
  end

  always_comb
  begin
    exec_word = field_word;
    show = (status_view_in == ESB_VIEW_FULL) ||
           (status_view_in == ESB_VIEW_EXEC);
    rdata_nxt = rdata_r;
    if (status_rd_in)
      rdata_nxt = (show && !status_direct_in) ? exec_word
                                              : 32'h00000000;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      rdata_r <= 32'h00000000;
    else
      rdata_r <= rdata_nxt;
  end

  // status_wr_in and data are accepted and dropped: the bits are read-only
  logic unused_wr;
  assign unused_wr = status_wr_in ^ (^status_wdata_in);

  assign status_rdata_out = rdata_r;
  assign isb_out = isb_r;
  assign resume_reg_out = resume_reg_r;
  assign resume_valid_out = resume_valid_r;
  assign cond_pass_out = pass_r;
  assign in_block_out = in_block_r;
  assign fault_out = fault_r;
  assign lockup_out = lockup_r;
endmodule
`default_nettype wire

// >>> bench/esb_exec_state_sva.sv
`timescale 1ns/1ps
`default_nettype none
module esb_exec_state_sva (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // causes
  input wire logic [31:0] rst_vector_in,
  input wire logic exc_entry_in,
  input wire logic [31:0] exc_vector_in,
  input wire logic exc_return_in,
  input wire logic [31:0] stacked_status_word_in,
  input wire logic branch_via_register_in,
  input wire logic [31:0] branch_target_in,
  input wire logic instr_issue_in,
  input wire logic status_rd_in,
  input wire logic status_direct_in,
  // effects
  input wire logic [31:0] status_rdata_out,
  input wire logic isb_out,
  input wire logic fault_out,
  input wire logic lockup_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////////////
  rsv_zero_a: assert property (
    status_rdata_out[23:16] == 8'h00 && status_rdata_out[9:6] == 4'h0)
    else $error("reserved bits not zero");
  rst_isb_a: assert property (
    $fell(sys_rst_in) |-> isb_out == $past(rst_vector_in[0]))
    else $error("state bit not from reset vector");
  entry_isb_a: assert property (
    exc_entry_in |=> isb_out == $past(exc_vector_in[0]))
    else $error("state bit not from entry vector");
  ret_isb_a: assert property (
    exc_return_in && !exc_entry_in
    |=> isb_out == $past(stacked_status_word_in[24]))
    else $error("state bit not restored on return");
  br_isb_a: assert property (
    branch_via_register_in && !exc_entry_in && !exc_return_in
    |=> isb_out == $past(branch_target_in[0]))
    else $error("state bit not from branch target");
  direct_rd_a: assert property (
    status_rd_in && status_direct_in |=> status_rdata_out == 32'h0)
    else $error("direct read not zero");
  clear_fault_a: assert property (
    instr_issue_in && !isb_out && !exc_entry_in |=> fault_out || lockup_out)
    else $error("no fault with state bit clear");
  lock_hold_a: assert property (
    lockup_out |=> lockup_out)
    else $error("lockup left without reset");
  entry_c: cover property (exc_entry_in);
  fault_c: cover property ($rose(fault_out));
  lock_c: cover property ($rose(lockup_out));
endmodule
bind esb_exec_state esb_exec_state_sva u_sva (
  .clk_sys_in, .sys_rst_in, .rst_vector_in, .exc_entry_in, .exc_vector_in,
  .exc_return_in, .stacked_status_word_in, .branch_via_register_in,
  .branch_target_in, .instr_issue_in, .status_rd_in, .status_direct_in,
  .status_rdata_out, .isb_out, .fault_out, .lockup_out
);
`default_nettype wire

// >>> bench/execution_state_bits_test.sv
`timescale 1ns/1ps
`default_nettype none
module execution_state_bits_test;
  import esb_pkg::*;
  logic clk_sys_in, sys_rst_in, exc_entry_in, exc_return_in;
  logic branch_via_register_in, branch_link_via_register_in;
  logic pop_into_program_counter_in, conditional_block_prefix_in;
  logic instr_issue_in, instr_done_in, multi_interrupt_in, multi_resume_in;
  logic status_rd_in, status_direct_in, status_wr_in, isb_out;
  logic [31:0] rst_vector_in, exc_vector_in, stacked_status_word_in;
  logic [31:0] branch_target_in, status_wdata_in, status_rdata_out, exp_w;
  logic [7:0] cond_block_state_in, s;
  logic [3:0] instr_cond_in, multi_next_reg_in, resume_reg_out, r;
  logic resume_valid_out, cond_pass_out, in_block_out, fault_out, lockup_out;
  esb_view_e status_view_in;
  int n_mismatch, cmp_count, seed, k, j;
  esb_exec_state u_dut (.*);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] full(logic [7:0] f, logic t);
    return {5'h00, f[7:6], t, 8'h00, f[5:0], 10'h000};
  endfunction
  // instructions in a block: lowest set mask bit marks the last one
  function automatic int blen(logic [3:0] m);
    return m[0] ? 4 : m[1] ? 3 : m[2] ? 2 : 1;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle;
    @(posedge clk_sys_in);
    {exc_entry_in, exc_return_in, branch_via_register_in, instr_issue_in,
     branch_link_via_register_in, pop_into_program_counter_in,
     conditional_block_prefix_in, instr_done_in, multi_interrupt_in,
     multi_resume_in, status_rd_in, status_wr_in} <= '0;
    #1;
  endtask
  task automatic rd(esb_view_e v, logic d);
    @(posedge clk_sys_in);
    status_rd_in <= 1'b1;
    status_view_in <= v;
    status_direct_in <= d;
    idle;
  endtask
  task automatic do_rst;
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    #1;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    n_mismatch++;
    stop_test;
  end
  initial
  begin
    seed = 73265;
    {exc_entry_in, exc_return_in, branch_via_register_in, instr_issue_in,
     branch_link_via_register_in, pop_into_program_counter_in,
     conditional_block_prefix_in, instr_done_in, multi_interrupt_in,
     multi_resume_in, status_rd_in, status_wr_in, status_direct_in} = '0;
    {exc_vector_in, stacked_status_word_in, branch_target_in} = '0;
    {status_wdata_in, cond_block_state_in, instr_cond_in} = '0;
    multi_next_reg_in = 4'h0;
    status_view_in = ESB_VIEW_FULL;
    rst_vector_in = 32'h00000001;
    sys_rst_in = 1'b1;
    do_rst;
    rd(ESB_VIEW_FULL, 1'b0);
    chk("status word", 32'h01000000, status_rdata_out);
    $display("reset test done");
    @(posedge clk_sys_in);
    conditional_block_prefix_in <= 1'b1;
    cond_block_state_in <= 8'h18;
    idle;
    for (k = 0; k < 2; k++)
    begin
      @(posedge clk_sys_in);
      instr_issue_in <= 1'b1;
      instr_cond_in <= {3'h0, k == 0};
      idle;
      chk("cond pass", k == 0, cond_pass_out);
    end
    repeat (20)
    begin
      s = 8'($random(seed));
      s[3] = s[3] | (s[2:0] == 3'h0);
      @(posedge clk_sys_in);
      conditional_block_prefix_in <= 1'b1;
      cond_block_state_in <= s;
      idle;
      rd(ESB_VIEW_FULL, 1'b0);
      chk("block field", full(s, 1'b1), status_rdata_out);
      for (j = 0; j < blen(s[3:0]); j++)
      begin
        chk("in block", 1, in_block_out);
        @(posedge clk_sys_in);
        instr_done_in <= 1'b1;
        idle;
      end
      chk("block end", 0, in_block_out);
    end
    $display("block test done");
    for (k = 0; k < 6; k++)
    begin
      @(posedge clk_sys_in);
      branch_via_register_in <= k % 3 == 0;
      branch_link_via_register_in <= k % 3 == 1;
      pop_into_program_counter_in <= k % 3 == 2;
      branch_target_in <= {31'($random(seed)), k >= 3};
      idle;
      chk("state bit", k >= 3, isb_out);
    end
    @(posedge clk_sys_in);
    status_wr_in <= 1'b1;
    status_wdata_in <= 32'hffffffff;
    idle;
    for (k = 0; k < 14; k++)
    begin
      rd(esb_view_e'(k / 2), k % 2 == 1);
      exp_w = (k == 0 || k == 2) ? full(8'h00, 1'b1) : 32'h00000000;
      chk("view", exp_w, status_rdata_out);
    end
    $display("view test done");
    @(posedge clk_sys_in);
    branch_via_register_in <= 1'b1;
    branch_target_in <= 32'h00000000;
    idle;
    @(posedge clk_sys_in);
    instr_issue_in <= 1'b1;
    idle;
    chk("fault", 1, fault_out);
    @(posedge clk_sys_in);
    exc_entry_in <= 1'b1;
    exc_vector_in <= 32'h00000000;
    idle;
    chk("lockup", 1, lockup_out);
    do_rst;
    chk("lockup", 0, lockup_out);
    chk("state bit", 1, isb_out);
    $display("fault test done");
    @(posedge clk_sys_in);
    exc_return_in <= 1'b1;
    stacked_status_word_in <= 32'h00000000;
    idle;
    chk("state bit", 0, isb_out);
    r = 4'($random(seed)) | 4'h1;
    @(posedge clk_sys_in);
    exc_entry_in <= 1'b1;
    multi_interrupt_in <= 1'b1;
    multi_next_reg_in <= r;
    exc_vector_in <= 32'h00000001;
    idle;
    rd(ESB_VIEW_FULL, 1'b0);
    chk("continuation", full({2'h0, r, 2'h0}, 1), status_rdata_out);
    @(posedge clk_sys_in);
    exc_return_in <= 1'b1;
    stacked_status_word_in <= full({2'h0, r, 2'h0}, 1'b1);
    idle;
    @(posedge clk_sys_in);
    multi_resume_in <= 1'b1;
    idle;
    chk("resume valid", 1, resume_valid_out);
    chk("resume reg", r, resume_reg_out);
    $display("transfer test done");
    stop_test;
  end
endmodule
`default_nettype wire
